// >>> rtl/fsl_pkg.sv
// Purpose: shared constants for the fiber, strap and indicator registers
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register offsets are word indices; byte address is index * 4
package fsl_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_FIBER_CFG = 12'h465;
  localparam logic [11:0] IDX_STRAP_ONE = 12'h467;
  localparam logic [11:0] IDX_STRAP_TWO = 12'h468;
  localparam logic [11:0] IDX_IND_CFG2 = 12'h469;
  localparam logic [ADDR_W-1:0] ADDR_FIBER_CFG = {IDX_FIBER_CFG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STRAP_ONE = {IDX_STRAP_ONE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STRAP_TWO = {IDX_STRAP_TWO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IND_CFG2 = {IDX_IND_CFG2, 2'h0};

  // ****************************************************************
  // reset values and write masks
  // ****************************************************************
  localparam logic [15:0] FIBER_CFG_RESET = 16'hFF00;
  localparam logic [15:0] FIBER_CFG_WMASK = 16'hFFFF;
  localparam logic [15:0] IND_CFG2_RESET = 16'h0040;
  localparam logic [15:0] IND_CFG2_WMASK = 16'h0770;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned SD_POL_BIT = 0;
  localparam int unsigned LED1_POL_BIT = 10;
  localparam int unsigned LED1_VAL_BIT = 9;
  localparam int unsigned LED1_FRC_BIT = 8;
  localparam int unsigned LED3_POL_BIT = 6;
  localparam int unsigned LED3_VAL_BIT = 5;
  localparam int unsigned LED3_FRC_BIT = 4;
  localparam logic [2:0] RXD3_MUX_LED3 = 3'h1;

  // ****************************************************************
  // strap latch vector layout and defaults
  // ****************************************************************
  localparam int unsigned STRAP_W = 20;
  localparam int unsigned ST_RXD1 = 0;
  localparam int unsigned ST_RXD0 = 2;
  localparam int unsigned ST_COL = 4;
  localparam int unsigned ST_RXER = 6;
  localparam int unsigned ST_CRS = 8;
  localparam int unsigned ST_RXDV = 10;
  localparam int unsigned ST_LED0 = 12;
  localparam int unsigned ST_RXD2 = 14;
  localparam int unsigned ST_RXD3 = 16;
  localparam int unsigned ST_SDEN = 18;
  localparam int unsigned ST_PULL = 19;
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_4 = 2'h3;
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 20'h033F0;

endpackage

// >>> rtl/strap_capture.sv
// Purpose: catches the strap levels once, on the first edge after reset
// Assumes: strap inputs are stable around reset release
// Notes: holds defaults until the capture edge, then never changes
`timescale 1ns/1ps
module strap_capture #(
  parameter int unsigned WIDTH = 20,
  parameter logic [WIDTH-1:0] DEFAULT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] strap_in,
  output logic [WIDTH-1:0] latched,
  output logic valid
);

  logic [WIDTH-1:0] latched_reg;
  logic [WIDTH-1:0] latched_next;
  logic valid_reg;
  logic valid_next;

  always_comb begin
    latched_next = latched_reg;
    valid_next = 1'b1;
    if (!valid_reg) begin
      latched_next = strap_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_reg <= DEFAULT;
      valid_reg <= 1'b0;
    end else begin
      latched_reg <= latched_next;
      valid_reg <= valid_next;
    end
  end

  assign latched = latched_reg;
  assign valid = valid_reg;

endmodule

// >>> rtl/fiber_sd_strap_led_regs.sv
// Purpose: fiber signal-detect, strap readback and indicator registers
// Assumes: APB slave, zero wait states, strap pins sampled after reset
// Notes: nine strap pins deliver a two-bit mode code each; signal-detect enable and indicator-one pull are single-bit straps
//
// How it works
// - fiber config bit 0 picks signal-detect polarity, 1 active low
// - active high polarity: link drops while signal-detect reads low
// - active low polarity: link drops while signal-detect reads high
// - indicator-one pin is signal-detect input only if strap enabled
// - each strap field is two read-only bits giving mode 1 to 4, except indicator-zero, which gives only mode 1 or 4
// - strap fields sit at fixed bit positions in two readback registers
// - indicator-zero strap field reads only mode 1 or mode 4
// - default straps read 11 for COL, RX_ER, CRS, indicator-zero
// - indicator config bit 10 is indicator-one polarity, set by pull
// - bits 8 and 9 force indicator-one to a fixed level
// - bit 6 is indicator-three polarity, reset to 1
// - bits 4 and 5 force indicator-three to a fixed level
// - RXD3 pin shows indicator-three only with pin-mux code 001
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module fiber_sd_strap_led_regs #(
  parameter int unsigned ADDR_WIDTH = fsl_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] strap_rxd1,
  input wire logic [1:0] strap_rxd0,
  input wire logic [1:0] strap_col,
  input wire logic [1:0] strap_rx_er,
  input wire logic [1:0] strap_crs,
  input wire logic [1:0] strap_rx_dv,
  input wire logic [1:0] strap_indicator_zero,
  input wire logic [1:0] strap_rxd2,
  input wire logic [1:0] strap_rxd3,
  input wire logic signal_detect_strap_enable,
  input wire logic indicator_one_pull_high,
  input wire logic indicator_one_i,
  output logic indicator_one_o,
  output logic indicator_one_oe,
  input wire logic indicator_one_func,
  input wire logic indicator_three_func,
  input wire logic [2:0] rxd3_mux_sel,
  input wire logic rxd3_normal,
  output logic rxd3_o,
  output logic fiber_link_drop
);
  import fsl_pkg::*;

  if (ADDR_WIDTH < ADDR_W) begin : g_addr_chk
    $error("ADDR_WIDTH too small for the register map");
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                               input logic [ADDR_W-1:0] base);
    hit = (a == ADDR_WIDTH'(base));
  endfunction

  logic sel_fiber;
  logic sel_strap1;
  logic sel_strap2;
  logic sel_cfg2;
  logic mapped;
  logic wr_access;
  logic setup;

  assign sel_fiber = hit(paddr, ADDR_FIBER_CFG);
  assign sel_strap1 = hit(paddr, ADDR_STRAP_ONE);
  assign sel_strap2 = hit(paddr, ADDR_STRAP_TWO);
  assign sel_cfg2 = hit(paddr, ADDR_IND_CFG2);
  assign mapped = sel_fiber | sel_strap1 | sel_strap2 | sel_cfg2;
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic [STRAP_W-1:0] strap_raw;
  logic [STRAP_W-1:0] strap_q;
  logic strap_valid;

  assign strap_raw = {indicator_one_pull_high, signal_detect_strap_enable,
                      strap_rxd3, strap_rxd2, strap_indicator_zero,
                      strap_rx_dv, strap_crs, strap_rx_er, strap_col,
                      strap_rxd0, strap_rxd1};

  strap_capture #(
    .WIDTH(STRAP_W),
    .DEFAULT(STRAP_DEFAULT)
  ) u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .strap_in(strap_raw),
    .latched(strap_q),
    .valid(strap_valid)
  );

  logic [1:0] led0_mode;
  logic [15:0] strap_one_val;
  logic [15:0] strap_two_val;
  logic sd_enabled;

  // indicator-zero folds reserved codes onto its upper bit
  assign led0_mode = strap_q[ST_LED0+1] ? MODE_4 : MODE_1;
  assign strap_one_val = {strap_q[ST_RXD1+:2], strap_q[ST_RXD0+:2],
                          strap_q[ST_COL+:2], strap_q[ST_RXER+:2],
                          strap_q[ST_CRS+:2], strap_q[ST_RXDV+:2],
                          2'h0, led0_mode};
  assign strap_two_val = {12'h000, strap_q[ST_RXD3+:2],
                          strap_q[ST_RXD2+:2]};
  assign sd_enabled = strap_q[ST_SDEN];

  // ****************************************************************
  // writable registers
  // ****************************************************************
  logic [15:0] fiber_reg;
  logic [15:0] fiber_next;
  logic [15:0] cfg2_reg;
  logic [15:0] cfg2_next;
  logic [15:0] wmask_bytes;

  assign wmask_bytes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    fiber_next = fiber_reg;
    cfg2_next = cfg2_reg;
    if (!strap_valid) begin
      cfg2_next[LED1_POL_BIT] = indicator_one_pull_high;
    end
    if (wr_access && sel_fiber) begin
      fiber_next = (fiber_reg & ~(FIBER_CFG_WMASK & wmask_bytes))
                 | (pwdata[15:0] & FIBER_CFG_WMASK & wmask_bytes);
    end
    if (wr_access && sel_cfg2) begin
      cfg2_next = (cfg2_reg & ~(IND_CFG2_WMASK & wmask_bytes))
                | (pwdata[15:0] & IND_CFG2_WMASK & wmask_bytes);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiber_reg <= FIBER_CFG_RESET;
      cfg2_reg <= IND_CFG2_RESET;
    end else begin
      fiber_reg <= fiber_next;
      cfg2_reg <= cfg2_next;
    end
  end

  // ****************************************************************
  // read data, loaded in the setup cycle
  // ****************************************************************
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (setup && !pwrite) begin
      rdata_next = 32'h0000_0000;
      if (sel_fiber) begin
        rdata_next[15:0] = fiber_reg;
      end else if (sel_strap1) begin
        rdata_next[15:0] = strap_one_val;
      end else if (sel_strap2) begin
        rdata_next[15:0] = strap_two_val;
      end else if (sel_cfg2) begin
        rdata_next[15:0] = cfg2_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;

  // ****************************************************************
  // pins: signal detect, indicator one, rxd3
  // ****************************************************************
  logic drop_reg;
  logic drop_next;
  logic led1_o_reg;
  logic led1_o_next;
  logic led1_oe_reg;
  logic led1_oe_next;
  logic rxd3_reg;
  logic rxd3_next;
  logic led3_level;

  always_comb begin
    drop_next = 1'b0;
    if (sd_enabled) begin
      if (fiber_reg[SD_POL_BIT]) begin
        drop_next = indicator_one_i;
      end else begin
        drop_next = ~indicator_one_i;
      end
    end
    // no pin drive until the straps are known
    led1_oe_next = strap_valid & ~sd_enabled;
    if (cfg2_reg[LED1_FRC_BIT]) begin
      led1_o_next = cfg2_reg[LED1_VAL_BIT];
    end else begin
      led1_o_next = cfg2_reg[LED1_POL_BIT] ? indicator_one_func
                                           : ~indicator_one_func;
    end
    if (cfg2_reg[LED3_FRC_BIT]) begin
      led3_level = cfg2_reg[LED3_VAL_BIT];
    end else begin
      led3_level = cfg2_reg[LED3_POL_BIT] ? indicator_three_func
                                          : ~indicator_three_func;
    end
    rxd3_next = (rxd3_mux_sel == RXD3_MUX_LED3) ? led3_level
                                                : rxd3_normal;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_reg <= 1'b0;
      led1_o_reg <= 1'b0;
      led1_oe_reg <= 1'b0;
      rxd3_reg <= 1'b0;
    end else begin
      drop_reg <= drop_next;
      led1_o_reg <= led1_o_next;
      led1_oe_reg <= led1_oe_next;
      rxd3_reg <= rxd3_next;
    end
  end

  assign fiber_link_drop = drop_reg;
  assign indicator_one_o = led1_o_reg;
  assign indicator_one_oe = led1_oe_reg;
  assign rxd3_o = rxd3_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sd_polarity_a: assert property (
    (wr_access && sel_fiber && pstrb[0]) |=>
      fiber_reg[SD_POL_BIT] == $past(pwdata[0]))
    else $error("signal-detect polarity bit not written");

  drop_active_high_a: assert property (
    (sd_enabled && !fiber_reg[SD_POL_BIT] && !indicator_one_i) |=>
      fiber_link_drop)
    else $error("link not dropped on low signal detect");

  drop_active_low_a: assert property (
    (sd_enabled && fiber_reg[SD_POL_BIT]) |=>
      fiber_link_drop == $past(indicator_one_i))
    else $error("link drop wrong with active low detect");

  sd_strap_gate_a: assert property (
    (strap_valid && !sd_enabled) |=> (!fiber_link_drop && indicator_one_oe))
    else $error("signal detect used without strap enable");

  strap_field_map_a: assert property (
    (setup && !pwrite && sel_strap1 && strap_valid) |=>
      prdata[15:4] == {strap_q[ST_RXD1+:2], strap_q[ST_RXD0+:2],
                       strap_q[ST_COL+:2], strap_q[ST_RXER+:2],
                       strap_q[ST_CRS+:2], strap_q[ST_RXDV+:2]})
    else $error("strap one readback fields misplaced");

  led0_code_a: assert property (
    (setup && !pwrite && sel_strap1) |=>
      (prdata[1:0] == MODE_1 || prdata[1:0] == MODE_4))
    else $error("indicator-zero strap reads a reserved code");

  strap_default_a: assert property (
    !strap_valid |-> ((strap_one_val == 16'h0FC3) &&
                      (strap_two_val == 16'h0000)))
    else $error("strap defaults wrong before capture");

  strap_readonly_a: assert property (
    (strap_valid && wr_access && (sel_strap1 || sel_strap2)) |=>
      $stable(strap_one_val) && $stable(strap_two_val))
    else $error("write changed strap readback");

  led1_force_a: assert property (
    cfg2_reg[LED1_FRC_BIT] |=> indicator_one_o == $past(cfg2_reg[LED1_VAL_BIT]))
    else $error("indicator-one not forced");

  led1_polarity_a: assert property (
    !cfg2_reg[LED1_FRC_BIT] |=>
      indicator_one_o == ($past(indicator_one_func) ~^
                          $past(cfg2_reg[LED1_POL_BIT])))
    else $error("indicator-one polarity wrong");

  rxd3_force_a: assert property (
    (rxd3_mux_sel == RXD3_MUX_LED3 && cfg2_reg[LED3_FRC_BIT]) |=>
      rxd3_o == $past(cfg2_reg[LED3_VAL_BIT]))
    else $error("rxd3 not forced");

  rxd3_mux_a: assert property (
    (rxd3_mux_sel != RXD3_MUX_LED3) |=> rxd3_o == $past(rxd3_normal))
    else $error("rxd3 shows indicator-three without mux code");

  led3_reset_a: assert property (
    !strap_valid |-> cfg2_reg[LED3_POL_BIT])
    else $error("indicator-three polarity not reset to one");

  link_drop_c: cover property (sd_enabled ##1 fiber_link_drop);
  led1_force_c: cover property (cfg2_reg[LED1_FRC_BIT] && indicator_one_oe);
  strap_read_c: cover property (setup && !pwrite && sel_strap1 ##1 pready);
  unmapped_c: cover property (pslverr);

endmodule

// >>> tb/fiber_partner.sv
// Purpose: model of the fiber transceiver and the indicator-one pin
// Assumes: transceiver output drives the pin only while device releases it
// Notes: device drive wins whenever its output enable is high
`timescale 1ns/1ps
module fiber_partner (
  input wire logic sd_level,
  input wire logic oe,
  input wire logic o,
  output logic pin
);
  // ****************************************************************
  // wire level resolved from both parties
  // ****************************************************************
  always_comb begin
    pin = oe ? o : sd_level;
  end
endmodule

// >>> tb/fiber_sd_strap_led_regs_bench.sv
// Purpose: self-checking bench for fiber, strap and indicator registers
// Assumes: zero wait state APB slave, outputs one edge behind inputs
// Notes: two resets, default straps then distinct strap codes
`timescale 1ns/1ps
module fiber_sd_strap_led_regs_bench;
  import fsl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] st [9];
  logic sden, pull, sd_level, func1, func3, rxnorm;
  logic ind1_o, ind1_oe, rxd3_o, drop;
  logic [2:0] mux;
  wire logic ind1_pin;
  int err_count, n_tests, cycles;

  fiber_sd_strap_led_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_rxd1(st[0]), .strap_rxd0(st[1]), .strap_col(st[2]),
    .strap_rx_er(st[3]), .strap_crs(st[4]), .strap_rx_dv(st[5]),
    .strap_indicator_zero(st[6]), .strap_rxd2(st[7]), .strap_rxd3(st[8]),
    .signal_detect_strap_enable(sden), .indicator_one_pull_high(pull),
    .indicator_one_i(ind1_pin), .indicator_one_o(ind1_o),
    .indicator_one_oe(ind1_oe), .indicator_one_func(func1),
    .indicator_three_func(func3), .rxd3_mux_sel(mux),
    .rxd3_normal(rxnorm), .rxd3_o(rxd3_o), .fiber_link_drop(drop)
  );

  fiber_partner partner (
    .sd_level(sd_level), .oe(ind1_oe), .o(ind1_o), .pin(ind1_pin)
  );

  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  task end_of_test;
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task do_reset(input logic [17:0] codes, input logic sd_v, pull_v);
    presetn <= 1'b0;
    sden <= sd_v;
    pull <= pull_v;
    for (int i = 0; i < 9; i++) begin
      st[i] <= codes[2*i +: 2];
    end
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task apb(input logic wr, input logic [13:0] a, input logic [15:0] d,
           output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [13:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    repeat (2) @(posedge pclk);
  endtask

  task rd(input logic [13:0] a, input logic [15:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 16'h0000, q, e);
    check(q, {16'h0000, exp});
  endtask

  task pin_set(input logic sd);
    sd_level <= sd;
    repeat (2) @(posedge pclk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_defaults;
    do_reset(18'h033F0, 1'b0, 1'b0);
    rd(ADDR_FIBER_CFG, 16'hFF00);
    rd(ADDR_STRAP_ONE, 16'h0FC3);
    rd(ADDR_STRAP_TWO, 16'h0000);
    rd(ADDR_IND_CFG2, 16'h0040);
  endtask

  task t_pins;
    func1 <= 1'b1;
    pin_set(1'b0);
    check(drop, 1'b0);
    check(ind1_oe, 1'b1);
    wr(ADDR_IND_CFG2, 16'h0340);
    check(ind1_o, 1'b1);
    wr(ADDR_IND_CFG2, 16'h0140);
    check(ind1_o, 1'b0);
    wr(ADDR_IND_CFG2, 16'h0440);
    check(ind1_o, 1'b1);
    wr(ADDR_IND_CFG2, 16'h0040);
    check(ind1_o, 1'b0);
    mux <= RXD3_MUX_LED3;
    func3 <= 1'b1;
    wr(ADDR_IND_CFG2, 16'h0040);
    check(rxd3_o, 1'b1);
    wr(ADDR_IND_CFG2, 16'h0000);
    check(rxd3_o, 1'b0);
    wr(ADDR_IND_CFG2, 16'h0030);
    check(rxd3_o, 1'b1);
    wr(ADDR_IND_CFG2, 16'h0050);
    check(rxd3_o, 1'b0);
    mux <= 3'h0;
    wr(ADDR_IND_CFG2, 16'h0030);
    check(rxd3_o, 1'b0);
    rxnorm <= 1'b1;
    repeat (2) @(posedge pclk);
    check(rxd3_o, 1'b1);
  endtask

  task t_straps;
    logic [31:0] q;
    logic e;
    do_reset(18'h26E49, 1'b1, 1'b1);
    rd(ADDR_STRAP_ONE, 16'h61B3);
    rd(ADDR_STRAP_TWO, 16'h0009);
    rd(ADDR_IND_CFG2, 16'h0440);
    wr(ADDR_STRAP_ONE, 16'hFFFF);
    wr(ADDR_STRAP_TWO, 16'hFFFF);
    rd(ADDR_STRAP_ONE, 16'h61B3);
    rd(ADDR_STRAP_TWO, 16'h0009);
    wr(ADDR_IND_CFG2, 16'hFFFF);
    rd(ADDR_IND_CFG2, 16'h0770);
    apb(1'b0, ADDR_FIBER_CFG + 14'h0004, 16'h0000, q, e);
    check(e, 1'b1);
    check(q, 32'h00000000);
  endtask

  task t_signal_detect;
    check(ind1_oe, 1'b0);
    pin_set(1'b0);
    check(drop, 1'b1);
    pin_set(1'b1);
    check(drop, 1'b0);
    wr(ADDR_FIBER_CFG, 16'hFF01);
    rd(ADDR_FIBER_CFG, 16'hFF01);
    check(drop, 1'b1);
    pin_set(1'b0);
    check(drop, 1'b0);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    for (int i = 0; i < 9; i++) begin
      st[i] = 2'h0;
    end
    sden = 1'b0;
    pull = 1'b0;
    sd_level = 1'b1;
    func1 = 1'b0;
    func3 = 1'b0;
    rxnorm = 1'b0;
    mux = 3'h0;
    err_count = 0;
    n_tests = 0;
    cycles = 0;
    t_defaults();
    t_pins();
    t_straps();
    t_signal_detect();
    end_of_test();
  end
endmodule
